/* File: shared/trig_port_map.vh */
// constants for the triggered output port block
// assumes one core clock and active-high synchronous reset
//
// Operation
// - trigger copies prepared buffer data into output latch and pins.
// - port 0 runs as two 4-bit channels or one 8-bit channel.
// - port 8 has one bit on 0 and two bits on 2-3.
// - port 0 upper nibble updates on timer 0 match 1.
// - port 0 lower nibble or byte updates on match 2 or interrupt 0.
// - port 8 bit 0 trigger is one of four selectable sources.
// - port 8 bits 2-3 output head switch values on match 0.
// - head switch and chroma outputs come from head switch control register.
// - writing head switch control changes those outputs at once.
// - port 8 bit 0 drives low, high or released at trigger.
// - port 8 bit 0 can superimpose separated horizontal sync.
// - pseudo vsync mode plays a fixed level pattern per trigger.
// - ports 0,3,4,5,6,8,9 set direction per bit.
// - ports 0,3,8,9 pull up only pins in input mode.
// - ports 2,7,10,11 input only; pull-ups only on port 2 bits 2-3.
// - port 0 has readable writable low and high buffers.
// - port 8 has a buffer whose reset value is all zeros.
`ifndef TRIG_PORT_MAP_VH
`define TRIG_PORT_MAP_VH

// ----------------------------------------
// register selects
// ----------------------------------------
`define SEL_P0 5'h00
`define SEL_P3 5'h03
`define SEL_P4 5'h04
`define SEL_P5 5'h05
`define SEL_P6 5'h06
`define SEL_P8 5'h08
`define SEL_P9 5'h09
`define SEL_PM0 5'h10
`define SEL_PM3 5'h13
`define SEL_PM4 5'h14
`define SEL_PM5 5'h15
`define SEL_PM6 5'h16
`define SEL_PM8 5'h18
`define SEL_PM9 5'h19
`define SEL_P0LB 5'h0a
`define SEL_P0HB 5'h0b
`define SEL_P8B 5'h0c
`define SEL_P8MC 5'h0d
`define SEL_HSOC 5'h0e
`define SEL_P0TC 5'h0f
`define SEL_TSS0 5'h1a

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_PM_ALL 8'hff
`define RST_PM8 8'hfd
`define RST_PM9 7'h7f
`define RST_ZERO 8'h00
`define RST_ZERO7 7'h00
`define RST_P8B 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define P0TC_LO_EN 0
`define P0TC_HI_EN 1
`define P0TC_BYTE 2
`define P0TC_SRC_INT 3
`define P8MC_B0 0
`define P8MC_B2 2
`define P8MC_B3 3
`define P8MC_PVS 4
`define P8MC_SUP 5
`define P8B_LVL 0
`define P8B_REL 1
`define HSOC_HEAD_AMP_SWITCH_SIGNAL 0
`define HSOC_ROTC 1
`define P8_HEAD 2
`define P8_CHROMA 3
`define NIB_LO 3:0
`define NIB_HI 7:4

// ----------------------------------------
// pseudo vsync pattern, two bits per step {release, level}
// ----------------------------------------
`define PVS_STEPS 3'h6
`define PVS_LAST 3'h5
`define PVS_PAT 12'h800
`define PORT8_PRESENT 8'hfd
`define PULL_GEN 39'h7f000000ff
`define PULL_IN 20'h0000c

`endif

/* File: design/port_pin_bank.v */
// pin bank: synchroniser, direction, release and pull-up for a port group
// assumes drive values and modes come from flops on core_clk
`timescale 1ns/1ps
`default_nettype none

module port_pin_bank #(
	parameter W = 8,
	parameter [W-1:0] PRESENT = {W{1'b1}},
	parameter [W-1:0] PULL = {W{1'b0}}
) (
	input wire core_clk,
	input wire rst,
	input wire [W-1:0] pin_in,
	input wire [W-1:0] drive_val,
	input wire [W-1:0] input_mode,
	input wire [W-1:0] release_pin,
	output wire [W-1:0] pin_out,
	output wire [W-1:0] pin_oe_n,
	output wire [W-1:0] pullup_en,
	output reg [W-1:0] pin_level_r
);

	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;

	// ----------------------------------------
	// three-stage pin synchroniser
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (rst) begin
			s1_r <= {W{1'b0}};
			s2_r <= {W{1'b0}};
			s3_r <= {W{1'b0}};
			pin_level_r <= {W{1'b0}};
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// accept only where stages two and three agree
			pin_level_r <= ((s2_r & s3_r) | (pin_level_r & (s2_r ^ s3_r))) & PRESENT;
		end
	end

	// ----------------------------------------
	// direction and pull-up
	// ----------------------------------------
	assign pin_out = drive_val & PRESENT;
	assign pin_oe_n = input_mode | release_pin | ~PRESENT;
	assign pullup_en = input_mode & PRESENT & PULL;

endmodule

`default_nettype wire

/* File: design/triggered_realtime_output_port.v */
// triggered output port for ports 0 and 8, plus general and input-only ports
// assumes timer events and horizontal sync are one-cycle or level signals on core_clk
`timescale 1ns/1ps
`default_nettype none
`include "trig_port_map.vh"

module triggered_realtime_output_port (
	input wire core_clk,
	input wire rst,
	input wire wr_en,
	input wire [4:0] wr_sel,
	input wire [7:0] wr_data,
	input wire [4:0] rd_sel,
	output reg [7:0] rd_data_r,
	input wire timer0_match0_event,
	input wire timer0_match1_event,
	input wire timer0_match2_event,
	input wire timer1_match3_event,
	input wire timer5_match_event,
	input wire external_interrupt0_event,
	input wire hsync_sep,
	input wire [7:0] port0_pin_in,
	output wire [7:0] port0_pin_out,
	output wire [7:0] port0_pin_oe_n,
	output wire [7:0] port0_pullup_en,
	input wire [7:0] port8_pin_in,
	output wire [7:0] port8_pin_out,
	output wire [7:0] port8_pin_oe_n,
	output wire [7:0] port8_pullup_en,
	input wire [38:0] gen_pin_in,
	output wire [38:0] gen_pin_out,
	output wire [38:0] gen_pin_oe_n,
	output wire [38:0] gen_pullup_en,
	input wire [19:0] inonly_pin_in,
	output wire [19:0] inonly_pullup_en
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [7:0] lat0_r;
	reg [7:0] lat3_r;
	reg [7:0] lat4_r;
	reg [7:0] lat5_r;
	reg [7:0] lat6_r;
	reg [7:0] lat8_r;
	reg [6:0] lat9_r;
	reg [7:0] pm0_r;
	reg [7:0] pm3_r;
	reg [7:0] pm4_r;
	reg [7:0] pm5_r;
	reg [7:0] pm6_r;
	reg [7:0] pm8_r;
	reg [6:0] pm9_r;
	reg [7:0] port0_low_buffer_r;
	reg [7:0] port0_high_buffer_r;
	reg [7:0] port8_buffer_r;
	reg [7:0] port8_mode_control_r;
	reg [7:0] head_switch_output_control_r;
	reg [7:0] port0_trigger_control_r;
	reg [7:0] trigger_source_select0_r;
	reg p80_drive_r;
	reg p80_rel_r;
	reg p80_lvl_r;
	reg p80_hold_rel_r;
	reg pvs_active_r;
	reg [2:0] pvs_step_r;
	reg hsync_d_r;

	wire [7:0] p0_lvl;
	wire [7:0] p8_lvl;
	wire [38:0] gen_lvl;
	wire [19:0] inonly_lvl;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [7:0] port_read;
		input [7:0] mode;
		input [7:0] lat;
		input [7:0] pin;
		begin
			port_read = (mode & pin) | (~mode & lat);
		end
	endfunction

	function wr_hit;
		input [4:0] sel;
		begin
			wr_hit = wr_en && (wr_sel == sel);
		end
	endfunction

	function [1:0] pvs_pat;
		input [2:0] step;
		reg [11:0] pat;
		begin
			pat = `PVS_PAT;
			pvs_pat = pat[{step, 1'b0} +: 2];
		end
	endfunction

	// ----------------------------------------
	// port 0 trigger decode
	// ----------------------------------------
	wire rtp_lo = port0_trigger_control_r[`P0TC_LO_EN];
	wire rtp_hi = port0_trigger_control_r[`P0TC_HI_EN];
	wire rtp_byte = port0_trigger_control_r[`P0TC_BYTE];
	wire trig_lo = port0_trigger_control_r[`P0TC_SRC_INT] ? external_interrupt0_event :
		timer0_match2_event;
	wire trig_hi = timer0_match1_event;
	wire [7:0] p0_rtp_mask = rtp_byte ? 8'hff : {{4{rtp_hi}}, {4{rtp_lo}}};

	// ----------------------------------------
	// port 8 trigger decode
	// ----------------------------------------
	reg trig_p80;
	always @* begin
		case (trigger_source_select0_r[1:0])
			2'h0: trig_p80 = timer0_match1_event;
			2'h1: trig_p80 = timer0_match2_event;
			2'h2: trig_p80 = timer1_match3_event;
			default: trig_p80 = timer5_match_event;
		endcase
	end

	wire p80_en = port8_mode_control_r[`P8MC_B0];
	wire p82_en = port8_mode_control_r[`P8MC_B2];
	wire p83_en = port8_mode_control_r[`P8MC_B3];
	wire pvs_mode = port8_mode_control_r[`P8MC_PVS];
	wire sup_en = port8_mode_control_r[`P8MC_SUP];
	wire hsw_wr = wr_hit(`SEL_HSOC);
	wire [7:0] p8_rtp_mask = {4'h0, p83_en, p82_en, 1'b0, p80_en};
	wire hsync_rise = hsync_sep && !hsync_d_r;

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (rst) begin
			lat3_r <= `RST_ZERO;
			lat4_r <= `RST_ZERO;
			lat5_r <= `RST_ZERO;
			lat6_r <= `RST_ZERO;
			lat9_r <= `RST_ZERO7;
			pm0_r <= `RST_PM_ALL;
			pm3_r <= `RST_PM_ALL;
			pm4_r <= `RST_PM_ALL;
			pm5_r <= `RST_PM_ALL;
			pm6_r <= `RST_PM_ALL;
			pm8_r <= `RST_PM8;
			pm9_r <= `RST_PM9;
			port0_low_buffer_r <= `RST_ZERO;
			port0_high_buffer_r <= `RST_ZERO;
			port8_buffer_r <= `RST_P8B;
			port8_mode_control_r <= `RST_ZERO;
			head_switch_output_control_r <= `RST_ZERO;
			port0_trigger_control_r <= `RST_ZERO;
			trigger_source_select0_r <= `RST_ZERO;
		end else if (wr_en) begin
			if (wr_sel == `SEL_P3) begin
				lat3_r <= wr_data;
			end else if (wr_sel == `SEL_P4) begin
				lat4_r <= wr_data;
			end else if (wr_sel == `SEL_P5) begin
				lat5_r <= wr_data;
			end else if (wr_sel == `SEL_P6) begin
				lat6_r <= wr_data;
			end else if (wr_sel == `SEL_P9) begin
				lat9_r <= wr_data[6:0];
			end else if (wr_sel == `SEL_PM0) begin
				pm0_r <= wr_data;
			end else if (wr_sel == `SEL_PM3) begin
				pm3_r <= wr_data;
			end else if (wr_sel == `SEL_PM4) begin
				pm4_r <= wr_data;
			end else if (wr_sel == `SEL_PM5) begin
				pm5_r <= wr_data;
			end else if (wr_sel == `SEL_PM6) begin
				pm6_r <= wr_data;
			end else if (wr_sel == `SEL_PM8) begin
				pm8_r <= wr_data;
			end else if (wr_sel == `SEL_PM9) begin
				pm9_r <= wr_data[6:0];
			end else if (wr_sel == `SEL_P0LB) begin
				port0_low_buffer_r <= wr_data;
			end else if (wr_sel == `SEL_P0HB) begin
				port0_high_buffer_r <= wr_data;
			end else if (wr_sel == `SEL_P8B) begin
				port8_buffer_r <= wr_data;
			end else if (wr_sel == `SEL_P8MC) begin
				port8_mode_control_r <= wr_data;
			end else if (wr_sel == `SEL_HSOC) begin
				head_switch_output_control_r <= wr_data;
			end else if (wr_sel == `SEL_P0TC) begin
				port0_trigger_control_r <= wr_data;
			end else if (wr_sel == `SEL_TSS0) begin
				trigger_source_select0_r <= wr_data;
			end
		end
	end

	// ----------------------------------------
	// port 0 output latch
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (rst) begin
			lat0_r <= `RST_ZERO;
		end else begin
			if (wr_hit(`SEL_P0)) begin
				lat0_r <= (wr_data & ~p0_rtp_mask) | (lat0_r & p0_rtp_mask);
			end
			if (rtp_byte) begin
				if (trig_lo) begin
					lat0_r <= {port0_high_buffer_r[`NIB_LO], port0_low_buffer_r[`NIB_LO]};
				end
			end else begin
				if (rtp_lo && trig_lo) begin
					lat0_r[`NIB_LO] <= port0_low_buffer_r[`NIB_LO];
				end
				if (rtp_hi && trig_hi) begin
					lat0_r[`NIB_HI] <= port0_high_buffer_r[`NIB_LO];
				end
			end
		end
	end

	// ----------------------------------------
	// port 8 output latch and head switch bits
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (rst) begin
			lat8_r <= `RST_ZERO;
		end else begin
			if (wr_hit(`SEL_P8)) begin
				lat8_r <= (wr_data & ~p8_rtp_mask) | (lat8_r & p8_rtp_mask);
			end
			if (p82_en && (timer0_match0_event || hsw_wr)) begin
				lat8_r[`P8_HEAD] <= hsw_wr ? wr_data[`HSOC_HEAD_AMP_SWITCH_SIGNAL] :
					head_switch_output_control_r[`HSOC_HEAD_AMP_SWITCH_SIGNAL];
			end
			if (p83_en && (timer0_match0_event || hsw_wr)) begin
				lat8_r[`P8_CHROMA] <= hsw_wr ? wr_data[`HSOC_ROTC] :
					head_switch_output_control_r[`HSOC_ROTC];
			end
		end
	end

	// ----------------------------------------
	// port 8 bit 0 three-level and pseudo vsync
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (rst) begin
			p80_lvl_r <= 1'b0;
			p80_hold_rel_r <= 1'b0;
			pvs_active_r <= 1'b0;
			pvs_step_r <= 3'h0;
			hsync_d_r <= 1'b0;
		end else begin
			hsync_d_r <= hsync_sep;
			if (p80_en && trig_p80) begin
				p80_lvl_r <= port8_buffer_r[`P8B_LVL];
				p80_hold_rel_r <= port8_buffer_r[`P8B_REL];
				pvs_active_r <= pvs_mode;
				pvs_step_r <= 3'h0;
			end else if (pvs_active_r && hsync_rise) begin
				if (pvs_step_r == `PVS_LAST) begin
					pvs_active_r <= 1'b0;
				end else begin
					pvs_step_r <= pvs_step_r + 3'h1;
				end
			end
		end
	end

	reg [1:0] p80_src;
	always @* begin
		if (pvs_active_r) begin
			p80_src = pvs_pat(pvs_step_r);
		end else begin
			p80_src = {p80_hold_rel_r, p80_lvl_r};
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			p80_drive_r <= 1'b0;
			p80_rel_r <= 1'b0;
		end else if (p80_en) begin
			p80_drive_r <= p80_src[0] & ~(sup_en & hsync_sep);
			p80_rel_r <= p80_src[1];
		end else begin
			p80_drive_r <= lat8_r[0];
			p80_rel_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// pin banks
	// ----------------------------------------
	port_pin_bank #(.W(8), .PULL(8'hff)) u_p0 (
		.core_clk(core_clk),
		.rst(rst),
		.pin_in(port0_pin_in),
		.drive_val(lat0_r),
		.input_mode(pm0_r),
		.release_pin(8'h00),
		.pin_out(port0_pin_out),
		.pin_oe_n(port0_pin_oe_n),
		.pullup_en(port0_pullup_en),
		.pin_level_r(p0_lvl)
	);

	port_pin_bank #(.W(8), .PRESENT(`PORT8_PRESENT), .PULL(8'hff)) u_p8 (
		.core_clk(core_clk),
		.rst(rst),
		.pin_in(port8_pin_in),
		.drive_val({lat8_r[7:1], p80_drive_r}),
		.input_mode(pm8_r),
		.release_pin({7'h00, p80_rel_r}),
		.pin_out(port8_pin_out),
		.pin_oe_n(port8_pin_oe_n),
		.pullup_en(port8_pullup_en),
		.pin_level_r(p8_lvl)
	);

	// order: port 9 (top), 6, 5, 4, 3 (bottom)
	port_pin_bank #(.W(39), .PULL(`PULL_GEN)) u_gen (
		.core_clk(core_clk),
		.rst(rst),
		.pin_in(gen_pin_in),
		.drive_val({lat9_r, lat6_r, lat5_r, lat4_r, lat3_r}),
		.input_mode({pm9_r, pm6_r, pm5_r, pm4_r, pm3_r}),
		.release_pin(39'h0),
		.pin_out(gen_pin_out),
		.pin_oe_n(gen_pin_oe_n),
		.pullup_en(gen_pullup_en),
		.pin_level_r(gen_lvl)
	);

	// order: port 11, 10, 7, 2 (bottom); never driven
	port_pin_bank #(.W(20), .PULL(`PULL_IN)) u_in (
		.core_clk(core_clk),
		.rst(rst),
		.pin_in(inonly_pin_in),
		.drive_val(20'h0),
		.input_mode(20'hfffff),
		.release_pin(20'h0),
		.pin_out(),
		.pin_oe_n(),
		.pullup_en(inonly_pullup_en),
		.pin_level_r(inonly_lvl)
	);

	// ----------------------------------------
	// read back
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (rst) begin
			rd_data_r <= `RST_ZERO;
		end else if (rd_sel == `SEL_P0) begin
			rd_data_r <= port_read(pm0_r, lat0_r, p0_lvl);
		end else if (rd_sel == `SEL_P3) begin
			rd_data_r <= port_read(pm3_r, lat3_r, gen_lvl[7:0]);
		end else if (rd_sel == `SEL_P4) begin
			rd_data_r <= port_read(pm4_r, lat4_r, gen_lvl[15:8]);
		end else if (rd_sel == `SEL_P5) begin
			rd_data_r <= port_read(pm5_r, lat5_r, gen_lvl[23:16]);
		end else if (rd_sel == `SEL_P6) begin
			rd_data_r <= port_read(pm6_r, lat6_r, gen_lvl[31:24]);
		end else if (rd_sel == `SEL_P8) begin
			rd_data_r <= port_read(pm8_r, lat8_r, p8_lvl) & `PORT8_PRESENT;
		end else if (rd_sel == `SEL_P9) begin
			rd_data_r <= port_read({1'b1, pm9_r}, {1'b0, lat9_r}, {1'b0, gen_lvl[38:32]});
		end else if (rd_sel == `SEL_PM0) begin
			rd_data_r <= pm0_r;
		end else if (rd_sel == `SEL_PM8) begin
			rd_data_r <= pm8_r;
		end else if (rd_sel == `SEL_P0LB) begin
			rd_data_r <= port0_low_buffer_r;
		end else if (rd_sel == `SEL_P0HB) begin
			rd_data_r <= port0_high_buffer_r;
		end else if (rd_sel == `SEL_P8B) begin
			rd_data_r <= port8_buffer_r;
		end else if (rd_sel == `SEL_P8MC) begin
			rd_data_r <= port8_mode_control_r;
		end else if (rd_sel == `SEL_HSOC) begin
			rd_data_r <= head_switch_output_control_r;
		end else if (rd_sel == `SEL_P0TC) begin
			rd_data_r <= port0_trigger_control_r;
		end else if (rd_sel == `SEL_TSS0) begin
			rd_data_r <= trigger_source_select0_r;
		end else begin
			rd_data_r <= {inonly_lvl[3:0], inonly_lvl[19:16]};
		end
	end

endmodule

`default_nettype wire

/* File: tb/trig_port_sva.sv */
// checker for the triggered output port, watching top-level ports only
// assumes single core_clk domain with synchronous active-high rst
`timescale 1ns/1ps
`default_nettype none
`include "trig_port_map.vh"

module trig_port_sva (
	input wire core_clk,
	input wire rst,
	input wire wr_en,
	input wire [4:0] wr_sel,
	input wire [7:0] wr_data,
	input wire timer0_match1_event,
	input wire timer0_match2_event,
	input wire timer1_match3_event,
	input wire timer5_match_event,
	input wire external_interrupt0_event,
	input wire [7:0] port0_pin_out,
	input wire [7:0] port0_pin_oe_n,
	input wire [7:0] port0_pullup_en,
	input wire [7:0] port8_pin_out,
	input wire [7:0] port8_pin_oe_n,
	input wire [7:0] port8_pullup_en,
	input wire [38:0] gen_pin_oe_n,
	input wire [38:0] gen_pullup_en,
	input wire [19:0] inonly_pullup_en
);
// ----------------------------------------
// shadow of control and buffer writes
// ----------------------------------------
reg [7:0] p0tc_r, p8mc_r, tss_r, lbuf_r, hbuf_r, p8buf_r;
wire lo_src = p0tc_r[3] ? external_interrupt0_event : timer0_match2_event;
wire [3:0] p8_srcs = {timer5_match_event, timer1_match3_event, timer0_match2_event, timer0_match1_event};
wire p8_ev = p8_srcs[tss_r[1:0]];
wire no_ev = !timer0_match1_event && !timer0_match2_event && !external_interrupt0_event;
always @(posedge core_clk) begin
	if (rst) begin
		p0tc_r <= 8'h00;
		p8mc_r <= 8'h00;
		tss_r <= 8'h00;
		lbuf_r <= 8'h00;
		hbuf_r <= 8'h00;
		p8buf_r <= 8'h00;
	end else if (wr_en) begin
		if (wr_sel == `SEL_P0TC) p0tc_r <= wr_data;
		if (wr_sel == `SEL_P8MC) p8mc_r <= wr_data;
		if (wr_sel == `SEL_TSS0) tss_r <= wr_data;
		if (wr_sel == `SEL_P0LB) lbuf_r <= wr_data;
		if (wr_sel == `SEL_P0HB) hbuf_r <= wr_data;
		if (wr_sel == `SEL_P8B) p8buf_r <= wr_data;
	end
end
// ----------------------------------------
// assertions
// ----------------------------------------
default clocking cb @(posedge core_clk); endclocking
default disable iff (rst);
sequence sq_p8_trig;
	p8_ev && p8mc_r[0] && !p8mc_r[4] && !p8mc_r[5] && !wr_en ##1 !p8_ev;
endsequence
chk_port0_pull_input: assert property (port0_pullup_en == port0_pin_oe_n)
	else $error("port0 pull-up not tied to input mode");
chk_pull_needs_input: assert property (((port8_pullup_en & ~port8_pin_oe_n) == 8'h00)
	&& ((gen_pullup_en & ~gen_pin_oe_n) == 39'h0)) else $error("pull-up on a driven pin");
chk_gen_pull_ports: assert property ((gen_pullup_en & ~39'h7f000000ff) == 39'h0)
	else $error("pull-up on port without pull-ups");
chk_inonly_pull: assert property (inonly_pullup_en == 20'h0000c)
	else $error("input-only pull-up pattern wrong");
chk_p8_bit_absent: assert property (port8_pin_oe_n[1] && !port8_pin_out[1] && !port8_pullup_en[1])
	else $error("port8 bit1 not absent");
chk_hi_nibble_trig: assert property (timer0_match1_event && p0tc_r[1] && !p0tc_r[2] && !wr_en
	|=> port0_pin_out[7:4] == $past(hbuf_r[3:0])) else $error("high nibble not loaded");
chk_lo_nibble_trig: assert property (lo_src && p0tc_r[0] && !p0tc_r[2] && !wr_en
	|=> port0_pin_out[3:0] == $past(lbuf_r[3:0])) else $error("low nibble not loaded");
chk_byte_trig: assert property (lo_src && p0tc_r[2:0] == 3'h7 && !wr_en
	|=> port0_pin_out == {$past(hbuf_r[3:0]), $past(lbuf_r[3:0])}) else $error("byte not loaded");
chk_latch_hold: assert property (!wr_en && no_ev |=> $stable(port0_pin_out))
	else $error("port0 changed without trigger or write");
chk_head_write_now: assert property (wr_en && wr_sel == `SEL_HSOC && p8mc_r[3:2] == 2'h3
	|=> port8_pin_out[3:2] == $past(wr_data[1:0])) else $error("head bits not immediate");
chk_p8b0_trig: assert property (sq_p8_trig |=> port8_pin_out[0] == $past(p8buf_r[0], 2))
	else $error("port8 bit0 not loaded");
endmodule
`default_nettype wire

/* File: tb/vcr_pin_load.sv */
// far-side model: recorder circuitry loading the port pins
// assumes per-bit external drive enables from the bench
`timescale 1ns/1ps
`default_nettype none

module vcr_pin_load #(
	parameter W = 8
) (
	input wire logic core_clk,
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pin_oe_n,
	input wire logic [W-1:0] pullup_en,
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_val,
	output logic [W-1:0] pin_level
);
// undriven, unpulled pins wander every cycle
logic [W-1:0] float_r = '0;
always @(posedge core_clk) begin
	float_r <= ~float_r;
end
assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
	| (pin_oe_n & ~ext_en & (pullup_en | float_r));
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// testbench for the triggered output port
// assumes the design files and trig_port_map.vh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "trig_port_map.vh"

module tb_top;
logic core_clk = 1'b0, rst = 1'b1, wr_en = 1'b0, hsync_sep = 1'b0;
logic [4:0] wr_sel = 5'h00, rd_sel = 5'h00;
logic [7:0] wr_data = 8'h00, ext_en0 = 8'h00, ext_val0 = 8'h00, ext_en8 = 8'h00, ext_val8 = 8'h00;
logic [38:0] ext_eng = 39'h0, ext_valg = 39'h0;
logic [5:0] ev = 6'h00;
logic [19:0] inonly_pin_in = 20'h00000;
wire [7:0] rd_data_r, p0_in, p0_out, p0_oe_n, p0_pu, p8_in, p8_out, p8_oe_n, p8_pu;
wire [38:0] g_in, g_out, g_oe_n, g_pu;
wire [19:0] io_pu;
int n_fail = 0, comparisons = 0;
always #4 core_clk = ~core_clk;
triggered_realtime_output_port uut (.core_clk(core_clk), .rst(rst), .wr_en(wr_en), .wr_sel(wr_sel),
	.wr_data(wr_data), .rd_sel(rd_sel), .rd_data_r(rd_data_r), .timer0_match0_event(ev[0]),
	.timer0_match1_event(ev[1]), .timer0_match2_event(ev[2]), .timer1_match3_event(ev[3]),
	.timer5_match_event(ev[4]), .external_interrupt0_event(ev[5]), .hsync_sep(hsync_sep),
	.port0_pin_in(p0_in), .port0_pin_out(p0_out), .port0_pin_oe_n(p0_oe_n), .port0_pullup_en(p0_pu),
	.port8_pin_in(p8_in), .port8_pin_out(p8_out), .port8_pin_oe_n(p8_oe_n), .port8_pullup_en(p8_pu),
	.gen_pin_in(g_in), .gen_pin_out(g_out), .gen_pin_oe_n(g_oe_n), .gen_pullup_en(g_pu),
	.inonly_pin_in(inonly_pin_in), .inonly_pullup_en(io_pu));
vcr_pin_load #(.W(8)) ld0 (.core_clk(core_clk), .pin_out(p0_out), .pin_oe_n(p0_oe_n), .pullup_en(p0_pu),
	.ext_en(ext_en0), .ext_val(ext_val0), .pin_level(p0_in));
vcr_pin_load #(.W(8)) ld8 (.core_clk(core_clk), .pin_out(p8_out), .pin_oe_n(p8_oe_n), .pullup_en(p8_pu),
	.ext_en(ext_en8), .ext_val(ext_val8), .pin_level(p8_in));
vcr_pin_load #(.W(39)) ldg (.core_clk(core_clk), .pin_out(g_out), .pin_oe_n(g_oe_n), .pullup_en(g_pu),
	.ext_en(ext_eng), .ext_val(ext_valg), .pin_level(g_in));
// ----------------------------------------
// shared tasks
// ----------------------------------------
task tick;
	@(posedge core_clk);
	#1;
endtask
task cmp(input logic [7:0] got, input logic [7:0] exp);
	comparisons++;
	if (got !== exp) begin
		n_fail++;
		$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
	end
endtask
task cmp_bit(input logic got, input logic exp);
	comparisons++;
	if (got !== exp) begin
		n_fail++;
		$display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
	end
endtask
task wr(input logic [4:0] s, input logic [7:0] d);
	wr_en = 1'b1;
	wr_sel = s;
	wr_data = d;
	tick;
	wr_en = 1'b0;
	tick;
endtask
task pulse(input int i);
	ev[i] = 1'b1;
	tick;
	ev[i] = 1'b0;
	tick;
endtask
task rd(input logic [4:0] s, input logic [7:0] exp);
	rd_sel = s;
	tick;
	cmp(rd_data_r, exp);
endtask
task close_out;
	$display("counts: comparisons %0d mismatches %0d", comparisons, n_fail);
	if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
	else $display("Testbench failed");
	$finish;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task t_reset;
	cmp(p0_oe_n, 8'hff);
	cmp(p0_pu, 8'hff);
	cmp(p8_pu, 8'hfd);
	cmp(io_pu[7:0], 8'h0c);
	cmp(io_pu[19:12], 8'h00);
	cmp(g_pu[7:0], 8'hff);
	cmp(g_pu[31:24], 8'h00);
	rd(`SEL_PM8, 8'hfd);
	$display("test reset done");
endtask
task t_plain;
	wr(`SEL_PM0, 8'h0f);
	wr(`SEL_P0, 8'ha5);
	cmp({p0_out[7:4], 4'h0}, 8'ha0);
	cmp(p0_oe_n, 8'h0f);
	cmp(p0_pu, 8'h0f);
	ext_en0 = 8'h0f;
	ext_val0 = 8'h06;
	repeat (6) tick;
	rd(`SEL_P0, 8'ha6);
	ext_en0 = 8'h00;
	$display("test plain port done");
endtask
task t_port0;
	wr(`SEL_PM0, 8'h00);
	wr(`SEL_P0LB, 8'h03);
	wr(`SEL_P0HB, 8'h0c);
	wr(`SEL_P0TC, 8'h03);
	pulse(1);
	cmp(p0_out, 8'hc5);
	pulse(2);
	cmp(p0_out, 8'hc3);
	wr(`SEL_P0, 8'h00);
	cmp(p0_out, 8'hc3);
	pulse(2);
	cmp(p0_out, 8'hc3);
	rd(`SEL_P0LB, 8'h03);
	wr(`SEL_P0TC, 8'h0f);
	wr(`SEL_P0LB, 8'h09);
	wr(`SEL_P0HB, 8'h05);
	pulse(2);
	cmp(p0_out, 8'hc3);
	pulse(5);
	cmp(p0_out, 8'h59);
	$display("test port0 done");
endtask
task t_p8b0;
	logic lvl;
	wr(`SEL_PM8, 8'h00);
	wr(`SEL_P8MC, 8'h01);
	for (int s = 0; s < 4; s++) begin
		lvl = ~s[0];
		wr(`SEL_TSS0, s[7:0]);
		wr(`SEL_P8B, {7'h00, lvl});
		pulse(((s + 1) % 4) + 1);
		cmp_bit(p8_out[0], ~lvl);
		pulse(s + 1);
		cmp_bit(p8_out[0], lvl);
	end
	wr(`SEL_P8B, 8'h02);
	pulse(4);
	cmp_bit(p8_oe_n[0], 1'b1);
	cmp_bit(p8_pu[0], 1'b0);
	wr(`SEL_P8MC, 8'h21);
	wr(`SEL_P8B, 8'h01);
	hsync_sep = 1'b1;
	pulse(4);
	tick;
	cmp_bit(p8_out[0], 1'b0);
	hsync_sep = 1'b0;
	repeat (2) tick;
	cmp_bit(p8_out[0], 1'b1);
	$display("test port8 bit0 done");
endtask
task t_head;
	wr(`SEL_HSOC, 8'h01);
	wr(`SEL_P8MC, 8'h0c);
	cmp({6'h00, p8_out[3:2]}, 8'h00);
	pulse(0);
	cmp({6'h00, p8_out[3:2]}, 8'h01);
	wr(`SEL_HSOC, 8'h02);
	cmp({6'h00, p8_out[3:2]}, 8'h02);
	$display("test head switch done");
endtask
task t_pvs;
	wr(`SEL_P8MC, 8'h11);
	wr(`SEL_TSS0, 8'h00);
	wr(`SEL_P8B, 8'h01);
	pulse(1);
	cmp({p8_oe_n[0], p8_out[0]}, 8'h00);
	for (int k = 1; k <= 6; k++) begin
		hsync_sep = 1'b1;
		repeat (3) tick;
		hsync_sep = 1'b0;
		tick;
		if (k == 5) cmp_bit(p8_oe_n[0], 1'b1);
	end
	cmp({p8_oe_n[0], p8_out[0]}, 8'h01);
	$display("test pseudo vsync done");
endtask
task t_gen;
	wr(`SEL_PM3, 8'h00);
	wr(`SEL_P3, 8'h3c);
	cmp(g_out[7:0], 8'h3c);
	cmp(g_oe_n[7:0], 8'h00);
	cmp(g_pu[7:0], 8'h00);
	inonly_pin_in = 20'ha0009;
	ext_en8 = 8'hf0;
	ext_val8 = 8'h50;
	ext_eng = 39'h7f00000000;
	ext_valg = 39'h1500000000;
	wr(`SEL_PM8, 8'hf0);
	cmp(p8_pu, 8'hf0);
	repeat (6) tick;
	rd(5'h1f, 8'h9a);
	rd(`SEL_P8, 8'h58);
	rd(`SEL_P9, 8'h15);
	$display("test general ports done");
endtask
// ----------------------------------------
// main sequence and watchdog
// ----------------------------------------
initial begin
	repeat (2) @(posedge core_clk);
	#1;
	rst = 1'b0;
	t_reset;
	t_plain;
	t_port0;
	t_p8b0;
	t_head;
	t_pvs;
	t_gen;
	close_out;
end
initial begin
	repeat (3000) @(posedge core_clk);
	n_fail++;
	$display("MISMATCH t=%0t watchdog expired", $time);
	close_out;
end
endmodule

bind triggered_realtime_output_port trig_port_sva chk (.core_clk(core_clk), .rst(rst), .wr_en(wr_en),
	.wr_sel(wr_sel), .wr_data(wr_data), .timer0_match1_event(timer0_match1_event),
	.timer0_match2_event(timer0_match2_event), .timer1_match3_event(timer1_match3_event),
	.timer5_match_event(timer5_match_event), .external_interrupt0_event(external_interrupt0_event),
	.port0_pin_out(port0_pin_out), .port0_pin_oe_n(port0_pin_oe_n), .port0_pullup_en(port0_pullup_en),
	.port8_pin_out(port8_pin_out), .port8_pin_oe_n(port8_pin_oe_n), .port8_pullup_en(port8_pullup_en),
	.gen_pin_oe_n(gen_pin_oe_n), .gen_pullup_en(gen_pullup_en), .inonly_pullup_en(inonly_pullup_en));
`default_nettype wire
